/* design/ocf_pkg.sv */
// shared constants for the overcurrent fault response block
package ocf_pkg;
	localparam logic [7:0] CMD_OC_RESPONSE = 8'h47;
	localparam logic [7:0] CMD_DIE_OT_RESPONSE = 8'hD6;
	localparam logic [7:0] OC_RESPONSE_RESET = 8'h00;
	localparam logic [7:0] DIE_OT_RESPONSE_VALUE = 8'hC0;
	localparam int RESP_HI = 7;
	localparam int RESP_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;
	localparam logic [1:0] RESP_LIMIT = 2'h0;
	localparam logic [1:0] RESP_UNSUPPORTED = 2'h1;
	localparam logic [1:0] RESP_DELAYED = 2'h2;
	localparam logic [1:0] RESP_IMMEDIATE = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam int SB_OTHER = 0;
	localparam int SB_OVERCURRENT_SUMMARY_BIT = 4;
	localparam int SW_IOUT = 14;
	localparam int SI_OC_FAULT = 7;
	localparam int DELAY_UNIT_MS = 16;
	localparam int CLK_MHZ = 200;
	localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * 1000 * CLK_MHZ;
	localparam int RETRY_INTERVAL_CYC = 200000;
	localparam int NUM_CHAN = 2;
endpackage : ocf_pkg

/* design/ocf_cfg_mem.sv */
// per-channel storage for the overcurrent response byte
`timescale 1ns/1ps
module ocf_cfg_mem #(
	parameter int DEPTH = ocf_pkg::NUM_CHAN
) (
	input wire logic mclk, // clock
	input wire logic rst, // async reset
	input wire logic wr_en, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] wr_addr, // write page
	input wire logic [7:0] wr_data, // write byte
	input wire logic [$clog2(DEPTH)-1:0] rd_addr, // read page
	output logic [7:0] rd_data, // registered read byte
	output logic [8*DEPTH-1:0] all_data // every stored byte
);
	logic [7:0] mem_reg [DEPTH];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= ocf_pkg::OC_RESPONSE_RESET;
			end
		end else if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem_reg[rd_addr];
		end
	end

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			all_data[8*i +: 8] = mem_reg[i];
		end
	end
endmodule : ocf_cfg_mem

/* design/ocf_fault_resp.sv */
// overcurrent fault response logic for two paged regulator channels
`timescale 1ns/1ps
// Functional notes
// - overcurrent sets other-fault, overcurrent summary, word iout, iout fault bits
// - every response raises host attention unless the notification is masked
// - fault bit holds until clear, on/off cycle, restore, soft reset, power
// - response 00 limits current forever; 01 unsupported
// - response 10 limits for delay, then follows retry field if still limiting
// - response 11 shuts down immediately, then follows retry field
// - retry none keeps output off until enable is cycled or power removed; a soft reset also restarts it
// - retry 111 restarts endlessly, spaced by the restart interval
// - delay field counts 16 ms units
// - delay applies only to delayed shutdown response
// - response command carries exactly one data byte each way
// - read-only non-paged byte 0xD6 reports die overheat response 0xC0
// - paged read/write byte 0x47 holds overcurrent response, default 0x00
module ocf_fault_resp #(
	parameter int DELAY_UNIT_CYC = ocf_pkg::DELAY_UNIT_CYC,
	parameter int RETRY_INTERVAL_CYC = ocf_pkg::RETRY_INTERVAL_CYC
) (
	input wire logic mclk, // 200 MHz clock
	input wire logic rst, // async reset, power cycle
	input wire logic cmd_valid, // one-cycle command strobe
	input wire logic [7:0] cmd_code, // command code
	input wire logic cmd_write, // 1 write, 0 read
	input wire logic [7:0] cmd_wdata, // single write data byte
	input wire logic cmd_page, // selected page
	input wire logic clear_faults, // clear faults pulse
	input wire logic restore_user_all, // restore stored settings pulse
	input wire logic soft_reset, // device soft reset pulse
	input wire logic [1:0] chan_on, // commanded on (enable pin and operation)
	input wire logic [1:0] oc_detect, // overcurrent seen per channel
	input wire logic [1:0] alert_mask, // mask host notification
	output logic rsp_valid, // read answer strobe
	output logic [7:0] rsp_data, // single read data byte
	output logic rsp_err, // unsupported command or value
	output logic [7:0] status_byte, // summary byte, selected page
	output logic [15:0] status_word, // summary word, selected page
	output logic [7:0] status_iout, // iout status, selected page
	output logic alert_n, // host attention, active low
	output logic [1:0] out_enable, // output drive enable
	output logic [1:0] curr_limit // hold current at limit
);
	// ****************************************
	// configuration store
	// ****************************************
	logic wr_oc;
	logic [7:0] mem_rd;
	logic [15:0] cfg_all;
	logic rd_pend_reg;
	logic rd_src_reg;

	always_comb begin
		wr_oc = cmd_valid && cmd_write &&
			cmd_code == ocf_pkg::CMD_OC_RESPONSE &&
			cmd_wdata[ocf_pkg::RESP_HI:ocf_pkg::RESP_LO] !=
			ocf_pkg::RESP_UNSUPPORTED;
	end

	ocf_cfg_mem #(.DEPTH(ocf_pkg::NUM_CHAN)) u_mem (
		.mclk(mclk),
		.rst(rst),
		.wr_en(wr_oc),
		.wr_addr(cmd_page),
		.wr_data(cmd_wdata),
		.rd_addr(cmd_page),
		.rd_data(mem_rd),
		.all_data(cfg_all)
	);

	// ****************************************
	// command port
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_pend_reg <= 1'b0;
			rd_src_reg <= 1'b0;
			rsp_err <= 1'b0;
		end else begin
			rd_pend_reg <= cmd_valid && !cmd_write &&
				(cmd_code == ocf_pkg::CMD_OC_RESPONSE ||
				cmd_code == ocf_pkg::CMD_DIE_OT_RESPONSE);
			rd_src_reg <= cmd_code == ocf_pkg::CMD_DIE_OT_RESPONSE;
			// write to read-only code, unknown code or response 01 refused
			rsp_err <= cmd_valid && ((cmd_write &&
				(cmd_code == ocf_pkg::CMD_DIE_OT_RESPONSE ||
				(cmd_code == ocf_pkg::CMD_OC_RESPONSE && !wr_oc))) ||
				(cmd_code != ocf_pkg::CMD_OC_RESPONSE &&
				cmd_code != ocf_pkg::CMD_DIE_OT_RESPONSE));
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
		end else begin
			rsp_valid <= rd_pend_reg;
			if (rd_pend_reg) begin
				rsp_data <= rd_src_reg ? ocf_pkg::DIE_OT_RESPONSE_VALUE :
					mem_rd;
			end
		end
	end

	// ****************************************
	// per-channel response
	// ****************************************
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_LIMIT = 4'h2,
		ST_OFF = 4'h4,
		ST_WAIT = 4'h8
	} ocf_state_t;

	ocf_state_t state_reg [2];
	logic [1:0] fault_reg;
	logic [1:0] on_d_reg;
	logic [31:0] tmr_reg [2];
	logic [1:0] clr_any;
	logic [7:0] cfg [2];

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			cfg[c] = cfg_all[8*c +: 8];
			// off-then-on shows as a falling enable
			clr_any[c] = clear_faults || restore_user_all || soft_reset ||
				(on_d_reg[c] && !chan_on[c]);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			on_d_reg <= 2'h0;
		end else begin
			on_d_reg <= chan_on;
		end
	end

	// detection wins over a clear arriving in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fault_reg <= 2'h0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (oc_detect[c] && chan_on[c]) begin
					fault_reg[c] <= 1'b1;
				end else if (clr_any[c]) begin
					fault_reg[c] <= 1'b0;
				end
			end
		end
	end

	function automatic logic [31:0] delay_cycles(input logic [2:0] units);
		delay_cycles = 32'(int'(units) * DELAY_UNIT_CYC);
	endfunction

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int c = 0; c < 2; c++) begin
				state_reg[c] <= ST_RUN;
				tmr_reg[c] <= 32'h0;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (!chan_on[c] || soft_reset) begin
					state_reg[c] <= ST_RUN;
					tmr_reg[c] <= 32'h0;
				end else begin
					case (state_reg[c])
					ST_RUN: begin
						if (oc_detect[c]) begin
							case (cfg[c][ocf_pkg::RESP_HI:ocf_pkg::RESP_LO])
							ocf_pkg::RESP_IMMEDIATE: begin
								state_reg[c] <= ST_OFF;
							end
							ocf_pkg::RESP_DELAYED: begin
								state_reg[c] <= ST_LIMIT;
								tmr_reg[c] <= delay_cycles(
									cfg[c][ocf_pkg::DELAY_HI:ocf_pkg::DELAY_LO]);
							end
							default: begin
								state_reg[c] <= ST_LIMIT;
								tmr_reg[c] <= 32'h0;
							end
							endcase
						end
					end
					ST_LIMIT: begin
						if (!oc_detect[c]) begin
							state_reg[c] <= ST_RUN;
						end else if (cfg[c][ocf_pkg::RESP_HI:ocf_pkg::RESP_LO] ==
							ocf_pkg::RESP_DELAYED) begin
							if (tmr_reg[c] == 32'h0) begin
								state_reg[c] <= ST_OFF;
							end else begin
								tmr_reg[c] <= tmr_reg[c] - 32'h1;
							end
						end
					end
					ST_OFF: begin
						// anything but 111 stays latched off
						if (cfg[c][ocf_pkg::RETRY_HI:ocf_pkg::RETRY_LO] ==
							ocf_pkg::RETRY_FOREVER) begin
							state_reg[c] <= ST_WAIT;
							tmr_reg[c] <= 32'(RETRY_INTERVAL_CYC);
						end
					end
					ST_WAIT: begin
						if (tmr_reg[c] == 32'h0) begin
							state_reg[c] <= ST_RUN;
						end else begin
							tmr_reg[c] <= tmr_reg[c] - 32'h1;
						end
					end
					default: begin
						state_reg[c] <= ST_RUN;
					end
					endcase
				end
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_enable <= 2'h0;
			curr_limit <= 2'h0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				out_enable[c] <= chan_on[c] && (state_reg[c] == ST_RUN ||
					state_reg[c] == ST_LIMIT);
				curr_limit[c] <= state_reg[c] == ST_LIMIT;
			end
		end
	end

	// status mirrors the sticky bit, one cycle behind it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status_byte <= 8'h00;
			status_word <= 16'h0000;
			status_iout <= 8'h00;
			alert_n <= 1'b1;
		end else begin
			status_byte <= 8'h00;
			status_word <= 16'h0000;
			status_iout <= 8'h00;
			status_byte[ocf_pkg::SB_OTHER] <= fault_reg[cmd_page];
			status_byte[ocf_pkg::SB_OVERCURRENT_SUMMARY_BIT] <= fault_reg[cmd_page];
			status_word[ocf_pkg::SB_OTHER] <= fault_reg[cmd_page];
			status_word[ocf_pkg::SB_OVERCURRENT_SUMMARY_BIT] <= fault_reg[cmd_page];
			status_word[ocf_pkg::SW_IOUT] <= fault_reg[cmd_page];
			status_iout[ocf_pkg::SI_OC_FAULT] <= fault_reg[cmd_page];
			alert_n <= !(|(fault_reg & ~alert_mask));
		end
	end
endmodule : ocf_fault_resp

/* bench/ocf_fault_resp_sva.sv */
// assertions on the ports of the overcurrent fault response block
`timescale 1ns/1ps
module ocf_fault_resp_sva (
	input wire logic mclk, // clock
	input wire logic rst, // reset
	input wire logic cmd_valid, // strobe
	input wire logic [7:0] cmd_code, // code
	input wire logic cmd_write, // write
	input wire logic [7:0] cmd_wdata, // byte
	input wire logic cmd_page, // page
	input wire logic clear_faults, // clear
	input wire logic restore_user_all, // restore
	input wire logic soft_reset, // soft reset
	input wire logic [1:0] chan_on, // on
	input wire logic [1:0] oc_detect, // overcurrent
	input wire logic [1:0] alert_mask, // mask
	input wire logic rsp_valid, // answer
	input wire logic [7:0] rsp_data, // answer byte
	input wire logic rsp_err, // refused
	input wire logic [7:0] status_byte, // summary
	input wire logic [15:0] status_word, // word
	input wire logic [7:0] status_iout, // iout
	input wire logic alert_n, // attention
	input wire logic [1:0] out_enable, // drive
	input wire logic [1:0] curr_limit // limit
);
	// ****************************************
	// shadow of page 0 response and clear causes
	// ****************************************
	logic [1:0] resp0;
	logic [2:0] clr_h;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) resp0 <= 2'h0;
		else if (cmd_valid && cmd_write && cmd_code == 8'h47 && !cmd_page
			&& cmd_wdata[7:6] != 2'h1) resp0 <= cmd_wdata[7:6];
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) clr_h <= 3'h0;
		else clr_h <= {clr_h[1:0], clear_faults | restore_user_all
			| soft_reset | ~chan_on[cmd_page]};
	end
	AST_RD_LAT: assert property (cmd_valid && !cmd_write
		&& cmd_code == 8'h47 |-> ##2 rsp_valid) else $error("no answer");
	AST_OT_VAL: assert property (cmd_valid && !cmd_write
		&& cmd_code == 8'hD6 |-> ##2 rsp_data == 8'hC0) else $error("bad ot");
	AST_OT_RO: assert property (cmd_valid && cmd_write
		&& cmd_code == 8'hD6 |=> rsp_err) else $error("ot written");
	AST_RESP01: assert property (cmd_valid && cmd_write
		&& cmd_code == 8'h47 && cmd_wdata[7:6] == 2'h1 |=> rsp_err)
		else $error("01 kept");
	AST_STATUS: assert property (oc_detect[0] && chan_on[0]
		&& !cmd_page ##1 !cmd_page ##1 !cmd_page |-> status_iout[7]
		&& status_byte[0] && status_byte[4] && status_word[14])
		else $error("status not set");
	AST_ALERT: assert property (oc_detect[0] && chan_on[0]
		&& !alert_mask[0] |-> ##2 !alert_n) else $error("no alert");
	AST_HOLD: assert property ($fell(status_iout[7]) |-> clr_h != 3'h0
		|| $past(cmd_page) != $past(cmd_page, 2))
		else $error("fault bit lost");
	AST_IMM: assert property (oc_detect[0] && chan_on[0]
		&& resp0 == 2'h3 |-> ##2 !out_enable[0]) else $error("not off");
	AST_LIMIT: assert property ((oc_detect[0] && chan_on[0]
		&& resp0 == 2'h0) [*3] |-> curr_limit[0]) else $error("no limit");
	AST_LIM_END: assert property (!oc_detect[0] [*3]
		|-> !curr_limit[0]) else $error("limit stuck");
endmodule : ocf_fault_resp_sva
bind ocf_fault_resp ocf_fault_resp_sva chk (.mclk(mclk), .rst(rst),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
	.cmd_wdata(cmd_wdata), .cmd_page(cmd_page), .clear_faults(clear_faults),
	.restore_user_all(restore_user_all), .soft_reset(soft_reset),
	.chan_on(chan_on), .oc_detect(oc_detect), .alert_mask(alert_mask),
	.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
	.status_byte(status_byte), .status_word(status_word),
	.status_iout(status_iout), .alert_n(alert_n), .out_enable(out_enable),
	.curr_limit(curr_limit));

/* bench/ocf_host_model.sv */
// host side command master for the fault response block
`timescale 1ns/1ps
module ocf_host_model (
	input wire logic mclk, // clock
	output logic cmd_valid, // strobe
	output logic [7:0] cmd_code, // code
	output logic cmd_write, // write
	output logic [7:0] cmd_wdata, // byte
	output logic cmd_page // page, held: it also picks status
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_write = 1'b0;
		cmd_wdata = 8'h00;
		cmd_page = 1'b0;
	end
	task xfer(input logic [7:0] code, input logic wr, input logic [7:0] d,
		input logic pg);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_write <= wr;
		cmd_wdata <= d;
		cmd_page <= pg;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		// idle byte flips so a stale value cannot pass for data
		cmd_wdata <= ~d;
	endtask : xfer
endmodule : ocf_host_model

/* bench/tb.sv */
// self-checking bench for the overcurrent fault response block
`timescale 1ns/1ps
module tb;
	logic mclk, rst, cmd_valid, cmd_write, cmd_page, clear_faults, soft_reset;
	logic rsp_valid, rsp_err, alert_n;
	logic restore_user_all;
	logic [7:0] cmd_code, cmd_wdata, rsp_data, status_byte, status_iout;
	logic [15:0] status_word;
	logic [1:0] chan_on, oc_detect, alert_mask, out_enable, curr_limit;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	// status and limit of channel 0, the alert shared by both channels and the enables of both channels packed for one compare
	wire logic [7:0] obs = {status_byte[4], status_byte[0], status_word[14],
		status_iout[7], alert_n, curr_limit[0], out_enable};
	ocf_host_model host (.mclk(mclk), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
		.cmd_page(cmd_page));
	ocf_fault_resp #(.DELAY_UNIT_CYC(20), .RETRY_INTERVAL_CYC(10)) dut (
		.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .cmd_page(cmd_page),
		.clear_faults(clear_faults),
		.restore_user_all(restore_user_all),
		.soft_reset(soft_reset), .chan_on(chan_on), .oc_detect(oc_detect),
		.alert_mask(alert_mask), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_err(rsp_err), .status_byte(status_byte),
		.status_word(status_word), .status_iout(status_iout),
		.alert_n(alert_n), .out_enable(out_enable), .curr_limit(curr_limit));
	// ****************************************
	// clock, watchdog and helpers
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task report_and_stop();
		if (miscompares == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task rd(input logic [7:0] code, input logic pg, input logic [7:0] exp);
		host.xfer(code, 1'b0, 8'h00, pg);
		step(1);
		chk("rsp_valid", {7'h00, rsp_valid}, 8'h01);
		chk("rsp_data", rsp_data, exp);
	endtask : rd
	task wr(input logic [7:0] code, input logic pg, input logic [7:0] d,
		input logic err);
		host.xfer(code, 1'b1, d, pg);
		#1;
		chk("rsp_err", {7'h00, rsp_err}, {7'h00, err});
	endtask : wr
	task oc(input logic v, input int n);
		@(posedge mclk);
		oc_detect <= {1'b0, v};
		step(n);
	endtask : oc
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		clear_faults = 1'b0;
		soft_reset = 1'b0;
		restore_user_all = 1'b0;
		chan_on = 2'h0;
		oc_detect = 2'h0;
		alert_mask = 2'h0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		chan_on <= 2'h3;
		rd(8'h47, 1'b0, 8'h00);
		rd(8'hD6, 1'b1, 8'hC0);
		wr(8'h47, 1'b1, 8'h9B, 1'b0);
		rd(8'h47, 1'b1, 8'h9B);
		rd(8'h47, 1'b0, 8'h00);
		wr(8'hD6, 1'b0, 8'h12, 1'b1);
		rd(8'hD6, 1'b0, 8'hC0);
		wr(8'h46, 1'b0, 8'h00, 1'b1);
		wr(8'h47, 1'b1, 8'h40, 1'b1);
		rd(8'h47, 1'b1, 8'h9B);
		rd(8'h47, 1'b0, 8'h00);
		chk("obs", obs, 8'h0B);
		oc(1'b1, 30);
		chk("obs", obs, 8'hF7);
		oc(1'b0, 4);
		chk("obs", obs, 8'hF3);
		@(posedge mclk) clear_faults <= 1'b1;
		@(posedge mclk) clear_faults <= 1'b0;
		step(3);
		chk("obs", obs, 8'h0B);
		wr(8'h47, 1'b0, 8'hC0, 1'b0);
		@(posedge mclk) alert_mask <= 2'h1;
		oc(1'b1, 3);
		chk("obs", obs, 8'hFA);
		oc(1'b0, 30);
		chk("obs", obs, 8'hFA);
		@(posedge mclk) chan_on <= 2'h2;
		@(posedge mclk) chan_on <= 2'h3;
		alert_mask <= 2'h0;
		step(4);
		chk("obs", obs, 8'h0B);
		wr(8'h47, 1'b0, 8'hFF, 1'b0);
		oc(1'b1, 3);
		chk("obs", obs, 8'hF2);
		oc(1'b0, 20);
		chk("obs", obs, 8'hF3);
		@(posedge mclk) restore_user_all <= 1'b1;
		@(posedge mclk) restore_user_all <= 1'b0;
		step(3);
		chk("obs", obs, 8'h0B);
		wr(8'h47, 1'b0, 8'h82, 1'b0);
		oc(1'b1, 33);
		chk("obs", obs, 8'hF7);
		step(20);
		chk("out_enable", {6'h00, out_enable}, 8'h02);
		oc(1'b0, 1);
		@(posedge mclk) soft_reset <= 1'b1;
		@(posedge mclk) soft_reset <= 1'b0;
		step(3);
		chk("obs", obs, 8'h0B);
		oc(1'b1, 20);
		oc(1'b0, 40);
		chk("obs", obs, 8'hF3);
		report_and_stop();
	end
endmodule : tb
